//--- common/ddm_pkg.sv
// shared constants and types for the data memory map decoder
package ddm_pkg;

    // data memory access kinds issued by the cpu core
    typedef enum logic [2:0] {
        OP_DIRECT,
        OP_INDIRECT,
        OP_BIT,
        OP_PUSH,
        OP_POP,
        OP_XMOV_PAGED,
        OP_XMOV_WIDE
    } ddm_op_t;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SFR,
        ST_FIFO_REQ,
        ST_FIFO_REL
    } ddm_state_t;

    // apb register indices, byte address is four times the index
    localparam logic [7:0] CFG_INDEX = 8'h85;
    localparam logic [7:0] PAGE_INDEX = 8'hAA;
    localparam logic [11:0] CFG_ADDR = {2'b00, CFG_INDEX, 2'b00};
    localparam logic [11:0] PAGE_ADDR = {2'b00, PAGE_INDEX, 2'b00};
    localparam logic [11:0] SP_ADDR = 12'h300;
    localparam logic [11:0] STATUS_ADDR = 12'h304;

    // register fields and reset values
    localparam int FAE_BIT = 6;
    localparam logic [5:0] CFG_FIXED = 6'h03;
    localparam logic [4:0] PAGE_RESET = 5'h00;
    localparam logic [7:0] SP_RESET = 8'h07;

    // internal ram map
    localparam logic [7:0] SFR_SPLIT = 8'h80;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam int IRAM_BYTES = 256;

    // on-chip external ram map
    localparam int EXTERNAL_DATA_RAM_BYTES = 3072;
    localparam logic [11:0] EXTERNAL_DATA_RAM_LARGE_SIZE = 12'hC00;
    localparam logic [5:0] FIFO_WINDOW_PAGE = 6'h01;

endpackage

//--- core/ddm_decoder.sv
// data memory map decoder: internal ram, stack, external_data_ram and fifo window
//
// Summary of operation
// - 256 bytes internal ram at 0x00..0xFF
// - lower 128 bytes reachable direct or indirect
// - four eight-register banks, chosen by status bits
// - indirect address from bank register zero/one
// - bytes 0x20..0x2F form 128 bit addresses
// - operand type picks bit or byte access
// - above 0x7F: direct to sfr, indirect ram
// - push writes pointer plus one, then increments
// - stack pointer resets to 0x07
// - 1024 or 3072 bytes external-space ram
// - paged move takes high byte from page
// - wide address aliases modulo 1k (small) or 4k (large)
// - page bits 7..5 read zero, 4..0 writable
// - page bits 4..3 only on large variant
// - unused fifo ram usable as general ram
// - fifo access on usb clock, extra cycles
// - fifo window at 0x0400..0x07FF when enabled
// - config bit 6 enable, bits 5..0 read 000011b
`timescale 1ns/10ps

module ddm_decoder (
    input wire logic pclk,
    input wire logic presetn,
    // apb register port
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu data memory port
    input wire logic cpu_req,
    input wire ddm_pkg::ddm_op_t cpu_op,
    input wire logic cpu_write,
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_ptr_sel,
    input wire logic [7:0] cpu_wdata,
    input wire logic [15:0] sixteen_bit_pointer,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    output logic cpu_done,
    output logic [7:0] cpu_rdata,
    // special function register space
    output logic sfr_req,
    output logic [7:0] sfr_addr,
    output logic sfr_write,
    output logic [7:0] sfr_wdata,
    output logic sfr_bit,
    output logic [2:0] sfr_bit_pos,
    input wire logic [7:0] sfr_rdata,
    // usb fifo ram, four-phase handshake into the usb domain
    output logic fifo_req,
    output logic [9:0] fifo_addr,
    output logic fifo_write,
    output logic [7:0] fifo_wdata,
    input wire logic fifo_ack,
    input wire logic [7:0] fifo_rdata,
    // variant strap: high for the 3072-byte part
    input wire logic large_ram_variant
);
    import ddm_pkg::*;

    // registered state of the block, apart from the memories and seen_clk
    typedef struct packed {
        ddm_state_t state;
        logic [7:0] sp;
        logic [4:0] page;
        logic fae;
        logic done;
        logic [7:0] rdata;
        logic [31:0] prdata;
        logic sfr_req;
        logic [7:0] sfr_addr;
        logic sfr_write;
        logic [7:0] sfr_wdata;
        logic sfr_bit;
        logic [2:0] bit_pos;
        logic fifo_req;
        logic [9:0] fifo_addr;
        logic fifo_write;
        logic [7:0] fifo_wdata;
        logic ack_meta;
        logic ack_sync;
        logic var_meta;
        logic var_sync;
    } ddm_regs_t;

    ddm_regs_t r; // current state
    ddm_regs_t next_r; // next state

    logic [7:0] iram [0:IRAM_BYTES-1]; // internal ram, upper half too
    logic [7:0] external_data_ram [0:EXTERNAL_DATA_RAM_BYTES-1]; // on-chip external-space ram

    logic iram_we; // internal ram write strobe
    logic [7:0] iram_waddr; // internal ram write address
    logic [7:0] iram_wdata; // internal ram write data
    logic external_data_ram_we; // external-space ram write strobe
    logic [11:0] external_data_ram_waddr; // external-space ram write index
    logic [7:0] external_data_ram_wdata; // external-space ram write data

    logic accept; // cpu request taken this cycle
    logic [1:0] bank; // active register bank
    logic [7:0] ptr; // working register zero or one value
    logic [7:0] bit_byte; // byte holding the addressed bit
    logic [7:0] bit_old; // current content of that byte
    logic [7:0] bit_new; // content after a bit write
    logic [4:0] page_eff; // page number after variant masking
    logic [15:0] xaddr; // full 16-bit external address
    logic [11:0] xidx; // aliased ram index
    logic apb_write; // apb write access phase
    logic apb_setup; // apb setup phase

    // true for offsets that the register file answers
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == CFG_ADDR) || (a == PAGE_ADDR) ||
                   (a == SP_ADDR) || (a == STATUS_ADDR);
    endfunction

    // handshake outputs answer at once, no wait states
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign apb_write = psel && penable && pwrite && addr_hit(paddr);
    assign apb_setup = psel && !penable;

    assign accept = (r.state == ST_IDLE) && cpu_req && !r.done;
    assign bank = {bank_select_high, bank_select_low};
    // bank base is bank times eight, register zero or one within it
    assign ptr = iram[{3'b000, bank, 2'b00, cpu_ptr_sel}];
    // bit address to byte: base plus bit address over eight
    assign bit_byte = BIT_AREA_BASE + {4'h0, cpu_addr[6:3]};
    assign bit_old = iram[bit_byte];
    // upper page bits are dropped on the small part
    assign page_eff = r.var_sync ? r.page
                                 : {2'b00, r.page[2:0]};
    assign xaddr = (cpu_op == OP_XMOV_PAGED) ?
                   {3'b000, page_eff, ptr} :
                   sixteen_bit_pointer;
    // alias over 64k modulo 1k on the small part, 4k on the large, upper bits ignored
    assign xidx = r.var_sync ? xaddr[11:0]
                             : {2'b00, xaddr[9:0]};

    // one bit replaced inside the addressed byte
    always_comb
    begin
        bit_new = bit_old;
        bit_new[cpu_addr[2:0]] = cpu_wdata[0];
    end

    // sequencer, apb register file and memory strobes
    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        iram_we = 1'b0;
        iram_waddr = 8'h00;
        iram_wdata = 8'h00;
        external_data_ram_we = 1'b0;
        external_data_ram_waddr = 12'h000;
        external_data_ram_wdata = 8'h00;

        // synchronisers for the foreign-domain inputs
        next_r.ack_meta = fifo_ack;
        next_r.ack_sync = r.ack_meta;
        next_r.var_meta = large_ram_variant;
        next_r.var_sync = r.var_meta;

        // read data is latched in setup so it is a flop in access
        if (apb_setup)
        begin
            unique case (paddr)
                CFG_ADDR: next_r.prdata =
                    {24'h000000, 1'b0, r.fae, CFG_FIXED};
                PAGE_ADDR: next_r.prdata =
                    {27'h0000000, r.page};
                SP_ADDR: next_r.prdata = {24'h000000, r.sp};
                STATUS_ADDR: next_r.prdata =
                    {28'h0000000, r.var_sync, r.fifo_req,
                     r.state};
                default: next_r.prdata = 32'h00000000;
            endcase
        end

        // register writes; reserved bits simply are not stored
        if (apb_write)
        begin
            unique case (paddr)
                CFG_ADDR: next_r.fae = pwdata[FAE_BIT];
                PAGE_ADDR: next_r.page = pwdata[4:0];
                SP_ADDR: next_r.sp = pwdata[7:0];
                default: next_r.sp = r.sp; // status is read-only
            endcase
        end

        unique case (r.state)
            // take one cpu request and do it, fifo and sfr excepted
            ST_IDLE:
            begin
                if (accept)
                begin
                    next_r.done = 1'b1;
                    unique case (cpu_op)
                        // direct: low half is ram, high half is sfr
                        OP_DIRECT:
                        begin
                            if (cpu_addr >= SFR_SPLIT)
                            begin
                                next_r.done = 1'b0;
                                next_r.sfr_req = 1'b1;
                                next_r.sfr_addr = cpu_addr;
                                next_r.sfr_write = cpu_write;
                                next_r.sfr_wdata = cpu_wdata;
                                next_r.sfr_bit = 1'b0;
                                next_r.state = ST_SFR;
                            end
                            else if (cpu_write)
                            begin
                                iram_we = 1'b1;
                                iram_waddr = cpu_addr;
                                iram_wdata = cpu_wdata;
                            end
                            else
                            begin
                                next_r.rdata = iram[cpu_addr];
                            end
                        end
                        // indirect reaches all 256 bytes of ram
                        OP_INDIRECT:
                        begin
                            if (cpu_write)
                            begin
                                iram_we = 1'b1;
                                iram_waddr = ptr;
                                iram_wdata = cpu_wdata;
                            end
                            else
                            begin
                                next_r.rdata = iram[ptr];
                            end
                        end
                        // bit operand: chosen by op, not by address
                        OP_BIT:
                        begin
                            if (cpu_addr >= SFR_SPLIT)
                            begin
                                next_r.done = 1'b0;
                                next_r.sfr_req = 1'b1;
                                next_r.sfr_addr =
                                    {cpu_addr[7:3], 3'b000};
                                next_r.sfr_write = cpu_write;
                                next_r.sfr_wdata = cpu_wdata;
                                next_r.sfr_bit = 1'b1;
                                next_r.bit_pos = cpu_addr[2:0];
                                next_r.state = ST_SFR;
                            end
                            else if (cpu_write)
                            begin
                                iram_we = 1'b1;
                                iram_waddr = bit_byte;
                                iram_wdata = bit_new;
                            end
                            else
                            begin
                                next_r.rdata =
                                    {7'h00, bit_old[cpu_addr[2:0]]};
                            end
                        end
                        // push: write above the last used byte
                        OP_PUSH:
                        begin
                            iram_we = 1'b1;
                            iram_waddr = r.sp + 8'h01;
                            iram_wdata = cpu_wdata;
                            next_r.sp = r.sp + 8'h01;
                        end
                        // pop: read last used byte, then step down
                        OP_POP:
                        begin
                            next_r.rdata = iram[r.sp];
                            next_r.sp = r.sp - 8'h01;
                        end
                        // external moves, paged or through the pointer
                        default:
                        begin
                            if (r.fae &&
                                xaddr[15:10] == FIFO_WINDOW_PAGE)
                            begin
                                // window onto fifo ram, slow path
                                next_r.done = 1'b0;
                                next_r.fifo_req = 1'b1;
                                next_r.fifo_addr = xaddr[9:0];
                                next_r.fifo_write = cpu_write;
                                next_r.fifo_wdata = cpu_wdata;
                                next_r.state = ST_FIFO_REQ;
                            end
                            else if (xidx < EXTERNAL_DATA_RAM_LARGE_SIZE)
                            begin
                                if (cpu_write)
                                begin
                                    external_data_ram_we = 1'b1;
                                    external_data_ram_waddr = xidx;
                                    external_data_ram_wdata = cpu_wdata;
                                end
                                else
                                begin
                                    next_r.rdata = external_data_ram[xidx];
                                end
                            end
                            else
                            begin
                                // top quarter of 4k has no ram
                                next_r.rdata = 8'h00;
                            end
                        end
                    endcase
                end
            end
            // sfr space answers in the cycle it is asked
            ST_SFR:
            begin
                next_r.sfr_req = 1'b0;
                next_r.done = 1'b1;
                next_r.rdata = r.sfr_bit ?
                    {7'h00, sfr_rdata[r.bit_pos]} : sfr_rdata;
                next_r.state = ST_IDLE;
            end
            // hold the request until the usb side acknowledges
            ST_FIFO_REQ:
            begin
                if (r.ack_sync)
                begin
                    // read data is steady while ack stays high
                    if (!r.fifo_write)
                    begin
                        next_r.rdata = fifo_rdata;
                    end
                    next_r.fifo_req = 1'b0;
                    next_r.state = ST_FIFO_REL;
                end
            end
            // wait for ack to drop so the next request is clean
            ST_FIFO_REL:
            begin
                if (!r.ack_sync)
                begin
                    next_r.done = 1'b1;
                    next_r.state = ST_IDLE;
                end
            end
        endcase
    end

    // state register; every field resets to a constant
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.state <= ST_IDLE;
            r.sp <= SP_RESET;
            r.page <= PAGE_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // memories carry no reset, contents are undefined at power-up
    always_ff @(posedge pclk)
    begin
        if (iram_we)
        begin
            iram[iram_waddr] <= iram_wdata;
        end
        if (external_data_ram_we)
        begin
            external_data_ram[external_data_ram_waddr] <= external_data_ram_wdata;
        end
    end

    // outputs straight from flops
    assign prdata = r.prdata;
    assign cpu_done = r.done;
    assign cpu_rdata = r.rdata;
    assign sfr_req = r.sfr_req;
    assign sfr_addr = r.sfr_addr;
    assign sfr_write = r.sfr_write;
    assign sfr_wdata = r.sfr_wdata;
    assign sfr_bit = r.sfr_bit;
    assign sfr_bit_pos = r.bit_pos;
    assign fifo_req = r.fifo_req;
    assign fifo_addr = r.fifo_addr;
    assign fifo_write = r.fifo_write;
    assign fifo_wdata = r.fifo_wdata;

    // first clock after reset, for the reset-value check
    logic seen_clk;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen_clk <= 1'b0;
        end
        else
        begin
            seen_clk <= 1'b1;
        end
    end

    sp_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !seen_clk |-> r.sp == SP_RESET)
        else $error("stack pointer not at reset value");

    push_addr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (accept && cpu_op == OP_PUSH && !apb_write) |->
        iram_we && iram_waddr == r.sp + 8'h01 ##1
        r.sp == $past(r.sp) + 8'h01)
        else $error("push did not use and advance pointer");

    low_direct_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (accept && cpu_op == OP_DIRECT && !cpu_addr[7]) |=>
        cpu_done && !sfr_req)
        else $error("low direct access not served by ram");

    sfr_route_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (accept && cpu_op == OP_DIRECT && cpu_addr[7]) |=>
        sfr_req && !cpu_done ##1 cpu_done && !sfr_req)
        else $error("high direct access not routed to sfr");

    cfg_fixed_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && paddr == CFG_ADDR) |->
        prdata[5:0] == CFG_FIXED && prdata[7] == 1'b0)
        else $error("config fixed bits read wrong");

    page_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && paddr == PAGE_ADDR) |->
        prdata[7:5] == 3'b000 && prdata[4:0] == r.page)
        else $error("page register readback wrong");

    fifo_window_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(fifo_req) |-> $past(r.fae) &&
        $past(xaddr[15:10]) == FIFO_WINDOW_PAGE)
        else $error("fifo reached outside its window");

    fifo_slow_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(fifo_req) |-> !cpu_done [*3])
        else $error("fifo access finished too early");

endmodule // ddm_decoder

//--- sim/ddm_far_model.sv
// far side model: usb fifo ram on a four-phase handshake, and sfr space
`timescale 1ns/10ps

module ddm_far_model (
    input wire logic pclk,
    input wire logic usb_slow,
    input wire logic fifo_req,
    input wire logic [9:0] fifo_addr,
    input wire logic fifo_write,
    input wire logic [7:0] fifo_wdata,
    output logic fifo_ack,
    output logic [7:0] fifo_rdata,
    input wire logic sfr_req,
    input wire logic [7:0] sfr_addr,
    output logic [7:0] sfr_rdata
);
    logic [7:0] fifo_mem [0:1023]; // 1k packet ram, usb side
    logic [2:0] delay; // usb side service time
    logic [7:0] last; // last byte handed out

    // sfr space answers a pattern of the address, flipped when not asked
    assign sfr_rdata = sfr_req ? (sfr_addr ^ 8'h5A) : ~(sfr_addr ^ 8'h5A);
    // read data only stands while ack is high, garbage otherwise
    assign fifo_rdata = fifo_ack ? last : ~last;

    initial
    begin
        fifo_ack = 1'b0;
        delay = 3'h0;
        last = 8'h00;
    end

    // four-phase responder; ack holds until request drops
    always @(posedge pclk)
    begin
        if (fifo_req && !fifo_ack)
        begin
            delay <= delay + 3'h1;
            // slow mode mimics a usb clock near its floor
            if (delay >= (usb_slow ? 3'h5 : 3'h0))
            begin
                if (fifo_write)
                    fifo_mem[fifo_addr] <= fifo_wdata;
                last <= fifo_mem[fifo_addr];
                fifo_ack <= 1'b1;
            end
        end
        else if (!fifo_req)
        begin
            fifo_ack <= 1'b0;
            delay <= 3'h0;
        end
    end
endmodule // ddm_far_model

//--- sim/data_memory_map_decoder_bench.sv
// self-checking bench for the data memory map decoder
`timescale 1ns/10ps

module data_memory_map_decoder_bench;
    import ddm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, rd;
    logic cpu_req, cpu_write, cpu_ptr_sel, cpu_done;
    logic bank_select_low, bank_select_high, large_ram_variant, usb_slow;
    ddm_op_t cpu_op;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, sfr_addr, sfr_wdata;
    logic [7:0] sfr_rdata, fifo_wdata, fifo_rdata;
    logic [15:0] sixteen_bit_pointer;
    logic sfr_req, sfr_write, sfr_bit, fifo_req, fifo_write, fifo_ack;
    logic [2:0] sfr_bit_pos;
    logic [9:0] fifo_addr;
    int n_errors = 0;
    int check_count = 0;
    int lat; // edges from request to sampled done

    ddm_decoder dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .cpu_req, .cpu_op, .cpu_write,
        .cpu_addr, .cpu_ptr_sel, .cpu_wdata, .sixteen_bit_pointer,
        .bank_select_low, .bank_select_high, .cpu_done, .cpu_rdata,
        .sfr_req, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_bit, .sfr_bit_pos,
        .sfr_rdata, .fifo_req, .fifo_addr, .fifo_write, .fifo_wdata,
        .fifo_ack, .fifo_rdata, .large_ram_variant);
    ddm_far_model far (.pclk, .usb_slow, .fifo_req, .fifo_addr,
        .fifo_write, .fifo_wdata, .fifo_ack, .fifo_rdata, .sfr_req,
        .sfr_addr, .sfr_rdata);

    // 125 MHz system clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            n_errors++;
            test_done();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // one cpu access; gap of one edge keeps requests apart
    task automatic cpu(input ddm_op_t op, input logic wr,
        input logic [15:0] x, input logic [7:0] d, input logic p);
        cpu_req <= 1'b1;
        cpu_op <= op;
        cpu_write <= wr;
        cpu_addr <= x[7:0];
        sixteen_bit_pointer <= x;
        cpu_wdata <= d;
        cpu_ptr_sel <= p;
        lat = 0;
        do
        begin
            @(posedge pclk);
            lat++;
        end
        while (cpu_done !== 1'b1 && lat < 40);
        if (cpu_done !== 1'b1)
        begin
            n_errors++;
            test_done();
        end
        rd = {24'h0, cpu_rdata};
        cpu_req <= 1'b0;
        @(posedge pclk);
    endtask

    // register reset values, fixed fields, unmapped place
    task automatic t_regs();
        apb(1'b0, SP_ADDR, 32'h0);
        check(q, 32'h07);
        apb(1'b0, PAGE_ADDR, 32'h0);
        check(q, 32'h00);
        apb(1'b1, CFG_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, CFG_ADDR, 32'h0);
        check(q, 32'h43);
        apb(1'b1, PAGE_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, PAGE_ADDR, 32'h0);
        check(q, 32'h1F);
        apb(1'b0, 12'h010, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, CFG_ADDR, 32'h0);
        apb(1'b0, CFG_ADDR, 32'h0);
        check(q, 32'h03);
    endtask

    // banks, pointers, upper ram against sfr space
    task automatic t_iram();
        cpu(OP_DIRECT, 1'b1, 16'h0000, 8'h45, 1'b0);
        cpu(OP_DIRECT, 1'b1, 16'h0045, 8'h3C, 1'b0);
        check(32'(lat), 32'h2);
        cpu(OP_INDIRECT, 1'b0, 16'h0000, 8'h00, 1'b0);
        check(rd, 32'h3C);
        bank_select_low <= 1'b1;
        cpu(OP_DIRECT, 1'b1, 16'h0009, 8'hC0, 1'b0);
        cpu(OP_INDIRECT, 1'b1, 16'h0000, 8'h77, 1'b1);
        cpu(OP_DIRECT, 1'b0, 16'h00C0, 8'h00, 1'b0);
        check(rd, 32'h9A);
        cpu(OP_INDIRECT, 1'b0, 16'h0000, 8'h00, 1'b1);
        check(rd, 32'h77);
        bank_select_high <= 1'b1;
        cpu(OP_DIRECT, 1'b1, 16'h0019, 8'h45, 1'b0);
        cpu(OP_INDIRECT, 1'b0, 16'h0000, 8'h00, 1'b1);
        check(rd, 32'h3C);
        bank_select_low <= 1'b0;
        bank_select_high <= 1'b0;
    endtask

    // bit view of 0x20..0x2F; same number as byte goes elsewhere
    task automatic t_bit();
        cpu(OP_DIRECT, 1'b1, 16'h0022, 8'h00, 1'b0);
        cpu(OP_DIRECT, 1'b1, 16'h0013, 8'hA5, 1'b0);
        cpu(OP_BIT, 1'b1, 16'h0013, 8'h01, 1'b0);
        cpu(OP_DIRECT, 1'b0, 16'h0022, 8'h00, 1'b0);
        check(rd, 32'h08);
        cpu(OP_DIRECT, 1'b0, 16'h0013, 8'h00, 1'b0);
        check(rd, 32'hA5);
        // bit above 0x7F goes to sfr byte 0xC0, bit 3 of its pattern
        cpu(OP_BIT, 1'b0, 16'h00C3, 8'h00, 1'b0);
        check(rd, 32'h01);
    endtask

    // first push lands at 0x08 and moves the pointer
    task automatic t_stack();
        cpu(OP_PUSH, 1'b1, 16'h0000, 8'hAB, 1'b0);
        cpu(OP_DIRECT, 1'b0, 16'h0008, 8'h00, 1'b0);
        check(rd, 32'hAB);
        apb(1'b0, SP_ADDR, 32'h0);
        check(q, 32'h08);
        // pop takes the last used byte back
        cpu(OP_POP, 1'b0, 16'h0000, 8'h00, 1'b0);
        check(rd, 32'hAB);
    endtask

    // reset in mid-run puts pointer and page back, memories keep data
    task automatic t_reset();
        apb(1'b1, SP_ADDR, 32'h30);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, SP_ADDR, 32'h0);
        check(q, 32'h07);
        apb(1'b0, PAGE_ADDR, 32'h0);
        check(q, 32'h00);
    endtask

    // paged and wide moves, aliasing on both variants
    task automatic t_external_data_ram();
        cpu(OP_DIRECT, 1'b1, 16'h0000, 8'h34, 1'b0);
        apb(1'b1, PAGE_ADDR, 32'h08);
        cpu(OP_XMOV_PAGED, 1'b1, 16'h0000, 8'h61, 1'b0);
        cpu(OP_XMOV_WIDE, 1'b0, 16'h1834, 8'h00, 1'b0);
        check(rd, 32'h61);
        large_ram_variant <= 1'b0;
        repeat (4) @(posedge pclk);
        cpu(OP_XMOV_PAGED, 1'b1, 16'h0000, 8'h72, 1'b0);
        cpu(OP_XMOV_WIDE, 1'b0, 16'h0434, 8'h00, 1'b0);
        check(rd, 32'h72);
        cpu(OP_XMOV_WIDE, 1'b1, 16'h0050, 8'h11, 1'b0);
    endtask

    // fifo window; no packet data is touched, only spare bytes
    task automatic t_fifo();
        apb(1'b1, CFG_ADDR, 32'h40);
        usb_slow <= 1'b1;
        cpu(OP_XMOV_WIDE, 1'b1, 16'h0450, 8'h99, 1'b0);
        check({24'h0, far.fifo_mem[10'h050]}, 32'h99);
        usb_slow <= 1'b0;
        cpu(OP_XMOV_WIDE, 1'b0, 16'h0450, 8'h00, 1'b0);
        check(rd, 32'h99);
        check(lat > 4 ? 32'h1 : 32'h0, 32'h1);
        apb(1'b1, CFG_ADDR, 32'h00);
        cpu(OP_XMOV_WIDE, 1'b0, 16'h0450, 8'h00, 1'b0);
        check(rd, 32'h11);
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        {presetn, psel, penable, pwrite, cpu_req, cpu_write} = 6'h00;
        {cpu_ptr_sel, bank_select_low, bank_select_high, usb_slow} = 4'h0;
        {paddr, pwdata, cpu_addr, cpu_wdata, sixteen_bit_pointer} = '0;
        cpu_op = OP_DIRECT;
        large_ram_variant = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_regs();
        t_iram();
        t_bit();
        t_stack();
        t_external_data_ram();
        t_reset();
        t_fifo();
        test_done();
    end
endmodule // data_memory_map_decoder_bench
